/* File: hw/cpsg_supervisor.sv */
`include "cpsg_consts.svh"

module cpsg_supervisor #(
  parameter int unsigned HOLD_CYCLES = `CPSG_HOLD_CYCLES,
  parameter int unsigned DEBOUNCE_CYCLES = `CPSG_DEBOUNCE_CYCLES,
  parameter int unsigned WDOG_CYCLES = `CPSG_WDOG_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_supply_ok,
  input wire logic i_above_switch,
  input wire logic i_fail_compare_in,
  input wire logic i_watchdog_kick_n,
  input wire logic i_cpu_reset_n,
  input wire logic i_sram_select_in_n,
  input wire logic i_status_flag,
  input wire logic i_irq_enable,
  output logic o_cpu_reset_n,
  output logic o_cpu_reset_oe_n,
  output logic o_sram_select_out_n,
  output logic o_sram_supply_out,
  output logic o_fail_warning_out_n,
  output logic o_irq
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [`CPSG_IN_W-1:0] raw;
  logic [`CPSG_IN_W-1:0] s1_r;
  logic [`CPSG_IN_W-1:0] s2_r;
  logic [`CPSG_IN_W-1:0] s3_r;
  logic [`CPSG_IN_W-1:0] filt_r;
  logic [`CPSG_IN_W-1:0] filt_nxt;

  assign raw = {i_sram_select_in_n, i_cpu_reset_n, i_watchdog_kick_n,
                i_fail_compare_in, i_above_switch, i_supply_ok};

  // A change counts only once the second and third stages agree
  always_comb
  begin
    filt_nxt = (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      s1_r <= `CPSG_SYNC_RST;
      s2_r <= `CPSG_SYNC_RST;
      s3_r <= `CPSG_SYNC_RST;
      filt_r <= `CPSG_SYNC_RST;
    end
    else
    begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= filt_nxt;
    end
  end

  logic sup_f;
  logic sw_f;
  logic cmp_f;
  logic kick_f;
  logic pin_f;
  logic sel_f;

  assign sup_f = filt_r[`CPSG_IN_SUPPLY];
  assign sw_f = filt_r[`CPSG_IN_SWITCH];
  assign cmp_f = filt_r[`CPSG_IN_CMP];
  assign kick_f = filt_r[`CPSG_IN_KICK];
  assign pin_f = filt_r[`CPSG_IN_PIN];
  assign sel_f = filt_r[`CPSG_IN_SEL];

  // ----------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------
  cpsg_pkg::cpsg_state_type state_r;
  cpsg_pkg::cpsg_state_type state_nxt;
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic [31:0] wdog_r;
  logic [31:0] wdog_nxt;
  logic [31:0] deb_r;
  logic [31:0] deb_nxt;
  logic kick_prev_r;
  logic kick_fall;
  logic drive_r;
  logic drive_nxt;
  logic ce_out_r;
  logic ce_out_nxt;
  logic supply_out_r;
  logic warn_r;
  logic irq_r;
  logic irq_nxt;

  assign kick_fall = kick_prev_r & ~kick_f;

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    wdog_nxt = 32'h0;
    deb_nxt = 32'h0;
    case (state_r)
      cpsg_pkg::cpsg_st_pfail:
      begin
        cnt_nxt = 32'h0;
        state_nxt = cpsg_pkg::cpsg_st_hold;
      end
      // Hold and pulse share one 250 ms count; kick and push-button are not sampled meanwhile
      cpsg_pkg::cpsg_st_hold, cpsg_pkg::cpsg_st_pulse:
      begin
        if (cnt_r == HOLD_CYCLES - 1)
        begin
          state_nxt = cpsg_pkg::cpsg_st_run;
          cnt_nxt = 32'h0;
        end
        else
        begin
          cnt_nxt = cnt_r + 32'h1;
        end
      end
      cpsg_pkg::cpsg_st_run:
      begin
        if (!kick_fall)
        begin
          wdog_nxt = wdog_r + 32'h1;
        end
        if (!pin_f)
        begin
          deb_nxt = deb_r + 32'h1;
        end
        if ((!kick_fall && wdog_r == WDOG_CYCLES - 1)
            || (!pin_f && deb_r == DEBOUNCE_CYCLES - 1))
        begin
          state_nxt = cpsg_pkg::cpsg_st_pulse;
          cnt_nxt = 32'h0;
          // Start clean, so no stale count survives into the lockout
          wdog_nxt = 32'h0;
          deb_nxt = 32'h0;
        end
      end
      default:
      begin
        state_nxt = cpsg_pkg::cpsg_st_pfail;
      end
    endcase
    // Supply loss overrides everything
    if (!sup_f)
    begin
      state_nxt = cpsg_pkg::cpsg_st_pfail;
      cnt_nxt = 32'h0;
      wdog_nxt = 32'h0;
      deb_nxt = 32'h0;
    end
  end

  always_comb
  begin
    drive_nxt = (state_nxt != cpsg_pkg::cpsg_st_run);
    // Chip enable follows the host only in run, latency of the synchroniser
    ce_out_nxt = (state_nxt == cpsg_pkg::cpsg_st_run) ? sel_f : 1'b1;
    irq_nxt = i_status_flag & i_irq_enable;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_r <= cpsg_pkg::cpsg_st_pfail;
      cnt_r <= 32'h0;
      wdog_r <= 32'h0;
      deb_r <= 32'h0;
      kick_prev_r <= 1'b1;
      drive_r <= 1'b1;
      ce_out_r <= 1'b1;
      supply_out_r <= 1'b0;
      warn_r <= 1'b1;
      irq_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      wdog_r <= wdog_nxt;
      deb_r <= deb_nxt;
      kick_prev_r <= kick_f;
      drive_r <= drive_nxt;
      ce_out_r <= ce_out_nxt;
      supply_out_r <= sw_f;
      warn_r <= cmp_f;
      irq_r <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  // Open drain: the data level is always low, only the enable moves
  assign o_cpu_reset_n = 1'b0;
  assign o_cpu_reset_oe_n = ~drive_r;
  assign o_sram_select_out_n = ce_out_r;
  assign o_sram_supply_out = supply_out_r;
  assign o_fail_warning_out_n = warn_r;
  assign o_irq = irq_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  a_fail_forces_reset: assert property (!sup_f |=> ##1 !o_cpu_reset_oe_n)
    else $error("supply loss did not drive reset");
  a_hold_stays: assert property ((state_r == cpsg_pkg::cpsg_st_hold && sup_f
      && cnt_r != HOLD_CYCLES - 1) |=> state_r == cpsg_pkg::cpsg_st_hold)
    else $error("reset hold ended early");
  a_pulse_stays: assert property ((state_r == cpsg_pkg::cpsg_st_pulse && sup_f
      && cnt_r != HOLD_CYCLES - 1) |=> !o_cpu_reset_oe_n)
    else $error("reset pulse too short");
  a_push_starts: assert property ((state_r == cpsg_pkg::cpsg_st_run && sup_f
      && !pin_f && deb_r == DEBOUNCE_CYCLES - 1) |=> ##1 !o_cpu_reset_oe_n)
    else $error("push-button not answered");
  a_wdog_fires: assert property ((state_r == cpsg_pkg::cpsg_st_run && sup_f
      && !kick_fall && wdog_r == WDOG_CYCLES - 1) |=> state_r == cpsg_pkg::cpsg_st_pulse)
    else $error("watchdog timeout missed");
  a_drain_only: assert property (o_cpu_reset_n == 1'b0
      && (o_cpu_reset_oe_n == (state_r == cpsg_pkg::cpsg_st_run)))
    else $error("reset pin drive wrong");
  a_lock_ignores: assert property (state_r != cpsg_pkg::cpsg_st_run
      |-> wdog_r == 32'h0 && deb_r == 32'h0 && o_sram_select_out_n)
    else $error("input taken during lockout");
  a_supply_switch: assert property ($changed(sw_f) |=> o_sram_supply_out == $past(sw_f))
    else $error("sram supply not switched");
  a_ce_blocked: assert property (!sup_f |=> ##1 o_sram_select_out_n)
    else $error("chip enable passed in transient");
  a_warn_follows: assert property (!cmp_f |=> !o_fail_warning_out_n)
    else $error("warning not asserted");
  // Checked one edge on, so the first edge after a reset sees no stale input
  a_irq_level: assert property (1'b1
      |=> o_irq == $past(i_status_flag && i_irq_enable))
    else $error("interrupt output wrong");
  a_kick_restart: assert property ((kick_fall && sup_f
      && state_r == cpsg_pkg::cpsg_st_run) |=> wdog_r == 32'h0)
    else $error("kick did not restart watchdog");

  c_power_up: cover property (state_r == cpsg_pkg::cpsg_st_hold
      ##1 state_r == cpsg_pkg::cpsg_st_run);
  c_wdog_pulse: cover property (wdog_r == WDOG_CYCLES - 1
      ##1 state_r == cpsg_pkg::cpsg_st_pulse);
  c_push_pulse: cover property (deb_r == DEBOUNCE_CYCLES - 1
      ##1 state_r == cpsg_pkg::cpsg_st_pulse);

endmodule : cpsg_supervisor

/* File: hw/cpsg_consts.svh */
`ifndef CPSG_CONSTS_SVH
`define CPSG_CONSTS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CPSG_CLK_KHZ 40000
`define CPSG_HOLD_MS 250
`define CPSG_DEBOUNCE_MS 10
`define CPSG_WDOG_MS 1500
`define CPSG_HOLD_CYCLES (`CPSG_HOLD_MS * `CPSG_CLK_KHZ)
`define CPSG_DEBOUNCE_CYCLES (`CPSG_DEBOUNCE_MS * `CPSG_CLK_KHZ)
`define CPSG_WDOG_CYCLES (`CPSG_WDOG_MS * `CPSG_CLK_KHZ)

// ----------------------------------------------------------------
// Synchronised input positions
// ----------------------------------------------------------------
`define CPSG_IN_SUPPLY 0
`define CPSG_IN_SWITCH 1
`define CPSG_IN_CMP 2
`define CPSG_IN_KICK 3
`define CPSG_IN_PIN 4
`define CPSG_IN_SEL 5
`define CPSG_IN_W 6
`define CPSG_SYNC_RST 6'h3c

`endif

/* File: hw/cpsg_pkg.sv */
package cpsg_pkg;

  // ----------------------------------------------------------------
  // Sequencer states, Gray along pfail-hold-run-pulse
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    cpsg_st_pfail = 2'h0,
    cpsg_st_hold = 2'h1,
    cpsg_st_run = 2'h3,
    cpsg_st_pulse = 2'h2
  } cpsg_state_type;

endpackage : cpsg_pkg

/* File: verification/cpsg_host_model.sv */
// ----------------------------------------
// Host and reset pin model
// ----------------------------------------
module cpsg_host_model (
  input wire logic i_clk,
  input wire logic i_kick_en,
  input wire logic i_button_n,
  input wire logic i_reset_oe_n,
  output logic o_kick_n,
  output logic o_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] phase_r = 4'h0;
  // Pull-up wins unless device or button sinks the pin
  assign o_pin_n = i_reset_oe_n & i_button_n;
  always_ff @(posedge i_clk)
  begin
    phase_r <= #1 phase_r + 4'h1;
  end
  // Two-cycle low every 16 cycles, so the input filter sees it
  assign o_kick_n = ~(i_kick_en & (phase_r < 4'h2));
endmodule : cpsg_host_model

/* File: verification/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Short counts keep the run small
  // ----------------------------------------
  localparam int HOLD = 20;
  localparam int DEB = 8;
  localparam int WDOG = 40;
  logic i_clk = 1'b0, i_rstn = 1'b0, sup = 1'b1, sw = 1'b1, cmp = 1'b1, sel = 1'b1;
  logic flag = 1'b0, en = 1'b0, kick_en = 1'b1, btn_n = 1'b1;
  logic kick_n, pin_n, rst_d, oe_n, sel_o, sup_o, warn_n, irq;
  logic [31:0] seed = 32'hbaf6;
  int n_fail = 0, comparisons = 0, n;
  cpsg_supervisor #(.HOLD_CYCLES(HOLD), .DEBOUNCE_CYCLES(DEB), .WDOG_CYCLES(WDOG))
    cpsg_supervisor_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_supply_ok(sup),
    .i_above_switch(sw), .i_fail_compare_in(cmp), .i_watchdog_kick_n(kick_n),
    .i_cpu_reset_n(pin_n), .i_sram_select_in_n(sel), .i_status_flag(flag),
    .i_irq_enable(en), .o_cpu_reset_n(rst_d), .o_cpu_reset_oe_n(oe_n),
    .o_sram_select_out_n(sel_o), .o_sram_supply_out(sup_o),
    .o_fail_warning_out_n(warn_n), .o_irq(irq));
  cpsg_host_model cpsg_host_model_inst (.i_clk(i_clk), .i_kick_en(kick_en),
    .i_button_n(btn_n), .i_reset_oe_n(oe_n), .o_kick_n(kick_n), .o_pin_n(pin_n));
  always #12.5 i_clk = ~i_clk;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  function automatic logic exp_irq(input logic f, input logic e);
    return f & e;
  endfunction : exp_irq
  task automatic give_verdict;
    $display("n_fail=%0d comparisons=%0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR at %0t: output %b, expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_span(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi)
    begin
      n_fail++;
      $display("ERROR at %0t: %0d cycles, expected %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_span
  task automatic step(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask : step
  // Bounded wait for the reset enable to reach a level
  task automatic wait_oe(input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while (oe_n !== lvl && cnt < lim)
    begin
      step(1);
      cnt++;
    end
  endtask : wait_oe
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    step(20);
    i_rstn = 1'b1;
    sel = 1'b0;
    step(5);
    chk_bit(oe_n, 1'b0);
    chk_bit(rst_d, 1'b0);
    chk_bit(sel_o, 1'b1);
    wait_oe(1'b1, HOLD + 20, n);
    chk_span(n, HOLD - 5, HOLD + 6);
    repeat (40)
    begin
      seed = xs(seed);
      {sw, sel, cmp, flag, en} = seed[4:0];
      step(8);
      chk_bit(sup_o, sw);
      chk_bit(sel_o, sel);
      chk_bit(warn_n, cmp);
      chk_bit(irq, exp_irq(flag, en));
      chk_bit(oe_n, 1'b1);
    end
    {sw, sel} = 2'h2;
    kick_en = 1'b0;
    wait_oe(1'b0, WDOG + 20, n);
    chk_span(n, WDOG - 16, WDOG + 8);
    kick_en = 1'b1;
    step(3);
    chk_bit(sel_o, 1'b1);
    wait_oe(1'b1, HOLD + 10, n);
    chk_span(n, HOLD - 4, HOLD + 3);
    step(3);
    btn_n = 1'b0;
    step(5);
    btn_n = 1'b1;
    step(20);
    chk_bit(oe_n, 1'b1);
    btn_n = 1'b0;
    wait_oe(1'b0, DEB + 20, n);
    btn_n = 1'b1;
    chk_span(n, DEB, DEB + 7);
    wait_oe(1'b1, HOLD + 10, n);
    chk_span(n, HOLD - 1, HOLD + 3);
    step(3);
    sup = 1'b0;
    wait_oe(1'b0, 12, n);
    chk_span(n, 3, 8);
    step(4);
    sup = 1'b1;
    wait_oe(1'b1, HOLD + 12, n);
    chk_span(n, HOLD, HOLD + 8);
    // Interrupt must also work with the SRAM on backup
    {sw, flag, en} = 3'h3;
    step(8);
    chk_bit(sup_o, 1'b0);
    chk_bit(irq, 1'b1);
    // Reset in mid-run drops back to pfail, then into the power-up hold once supply is resynchronised
    i_rstn = 1'b0;
    step(2);
    chk_bit(oe_n, 1'b0);
    chk_bit(sel_o, 1'b1);
    i_rstn = 1'b1;
    wait_oe(1'b1, HOLD + 12, n);
    chk_span(n, HOLD + 4, HOLD + 6);
    give_verdict();
  end
  initial
  begin
    #75000;
    n_fail++;
    give_verdict();
  end
endmodule : tb_top
